// ==== logic/oda_regs.vh ====
// Register map, field positions, reset values and timing counts for the
// output divider alignment control block. Included by the block's logic.
`ifndef ODA_REGS_VH
`define ODA_REGS_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define ODA_IDX_BURST       12'h13e
`define ODA_IDX_POWER       12'h140
`define ODA_IDX_CONFIG      12'h143
`define ODA_IDX_EXCLUDE     12'h144
`define ODA_IDX_STATUS      12'h150

// ------------------------------------------------------------
// Config and power fields
// ------------------------------------------------------------
`define ODA_CFG_CLEAR_SETUP 7
`define ODA_CFG_EDGE        6
`define ODA_CFG_INVERT      5
`define ODA_CFG_ENABLE      4
`define ODA_CFG_LOOP2       3
`define ODA_CFG_LOOP1       2
`define ODA_CFG_MODE_HI     1
`define ODA_CFG_MODE_LO     0
`define ODA_POWER_FRAME_PD  2

`define ODA_MODE_BLOCKED    2'h0
`define ODA_MODE_DIRECT     2'h1
`define ODA_MODE_PULSER_PIN 2'h2
`define ODA_MODE_PULSER_SW  2'h3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ODA_CONFIG_RESET    8'h01
`define ODA_EXCLUDE_RESET   8'h00
`define ODA_POWER_RESET     8'h00
`define ODA_BURST_RESET     8'h00

// ------------------------------------------------------------
// Timing: clock period and minimum hold of an edge-triggered event, in ns and in cycles
// ------------------------------------------------------------
`define ODA_CLK_NS          40
`define ODA_ONESHOT_NS      400
`define ODA_ONESHOT_CYC     ((`ODA_ONESHOT_NS + `ODA_CLK_NS - 1) / `ODA_CLK_NS)
`define ODA_PULSE_CYC       2

`endif

// ==== logic/oda_align_ctrl.v ====
// Output divider alignment control: AXI4-Lite registers, request pin
// conditioning, event generation and per-output divider reset.
// Assumes one clock aclk (25 MHz), synchronous active-low aresetn, and an
// asynchronous request pin and lock flags that are synchronised here.
//
// Behaviour
// - No alignment event is raised unless the enable bit (bit 4) is set.
// - The request pin is active high with invert bit 5 clear, low when set.
// - Level mode (bit 6 clear) holds outputs aligned while the request lasts.
// - Edge mode (bit 6 set) aligns on the rising edge for a minimum time.
// - Bit 3 holds the request asserted until loop 2 reports lock.
// - Bit 2 holds the request asserted until loop 1 reports lock.
// - Source select 0 blocks pin and both lock holds from making events.
// - Source select 1 makes events from the pin or enabled lock holds.
// - Source select 2 makes pulser pulses from the pin or lock holds.
// - Source select 3 makes pulser pulses on each burst count write.
// - Exclude bit 7 keeps the SYSREF clocks running through an event.
// - Exclude bits 6 to 0 keep each even device clock out of an event.
// - An excluded output is not interrupted while SYSREF is output.
// - With SYSREF powered down no SYSREF mode and no event occur.
`include "oda_regs.vh"

module oda_align_ctrl
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        align_request_pin,
    input  wire        loop1_lock,
    input  wire        loop2_lock,
    output reg  [6:0]  divider_reset,
    output reg         frame_ref_reset,
    output reg         pulser_trigger,
    output reg         frame_ref_enable,
    output reg         clear_setup_active
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    localparam [1:0] RESP_OKAY   = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;

    // Byte address to register index, low two address bits dropped
    function [11:0] reg_index;
        input [11:0] addr;
        begin
            reg_index = {2'h0, addr[11:2]};
        end
    endfunction

    // Known register index check
    function mapped;
        input [11:0] idx;
        begin
            if (idx == `ODA_IDX_BURST || idx == `ODA_IDX_POWER)
                mapped = 1'b1;
            else if (idx == `ODA_IDX_CONFIG || idx == `ODA_IDX_EXCLUDE)
                mapped = 1'b1;
            else if (idx == `ODA_IDX_STATUS)
                mapped = 1'b1;
            else
                mapped = 1'b0;
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]  cfg;
    reg  [7:0]  exclude;
    reg  [7:0]  power;
    reg  [7:0]  burst;
    reg  [11:0] aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;
    reg         burst_written;

    wire        aw_fire = s_axi_awvalid && s_axi_awready;
    wire        w_fire  = s_axi_wvalid && s_axi_wready;
    wire        do_write = aw_held && w_held && !s_axi_bvalid;
    wire [11:0] widx = reg_index(aw_addr);

    // Write channel capture, in either order, and register update
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr       <= 12'h000;
            aw_held       <= 1'b0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            w_held        <= 1'b0;
            cfg           <= `ODA_CONFIG_RESET;
            exclude       <= `ODA_EXCLUDE_RESET;
            power         <= `ODA_POWER_RESET;
            burst         <= `ODA_BURST_RESET;
            burst_written <= 1'b0;
        end
        else
        begin
            burst_written <= 1'b0;
            if (aw_fire)
            begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_fire)
            begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(widx) ? RESP_OKAY : RESP_SLVERR;
                if (w_strb[0])
                begin
                    if (widx == `ODA_IDX_CONFIG)
                        cfg <= w_data[7:0];
                    else if (widx == `ODA_IDX_EXCLUDE)
                        exclude <= w_data[7:0];
                    else if (widx == `ODA_IDX_POWER)
                        power <= w_data[7:0];
                    else if (widx == `ODA_IDX_BURST)
                    begin
                        burst         <= w_data[7:0];
                        burst_written <= 1'b1;
                    end
                end
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Request conditioning
    // ------------------------------------------------------------
    reg  [1:0] pin_sync;
    reg  [1:0] l1_sync;
    reg  [1:0] l2_sync;
    reg        pin_prev;
    reg        l1_hold;
    reg        l2_hold;

    wire [1:0] mode      = cfg[`ODA_CFG_MODE_HI:`ODA_CFG_MODE_LO];
    wire       enabled   = cfg[`ODA_CFG_ENABLE] && !power[`ODA_POWER_FRAME_PD];
    wire       pin_level = pin_sync[1] ^ cfg[`ODA_CFG_INVERT];
    wire       request   = pin_level || l1_hold || l2_hold;
    wire       req_rise  = request && !pin_prev;

    // Two-stage synchronisers and lock hold flags
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_sync <= 2'h0;
            l1_sync  <= 2'h0;
            l2_sync  <= 2'h0;
            pin_prev <= 1'b0;
            l1_hold  <= 1'b0;
            l2_hold  <= 1'b0;
        end
        else
        begin
            pin_sync <= {pin_sync[0], align_request_pin};
            l1_sync  <= {l1_sync[0], loop1_lock};
            l2_sync  <= {l2_sync[0], loop2_lock};
            pin_prev <= request;
            l1_hold  <= cfg[`ODA_CFG_LOOP1] && !l1_sync[1];
            l2_hold  <= cfg[`ODA_CFG_LOOP2] && !l2_sync[1];
        end
    end

    // ------------------------------------------------------------
    // Event generation
    // ------------------------------------------------------------
    localparam [31:0] ONESHOT_LOAD = `ODA_ONESHOT_CYC - 1;

    reg  [4:0] oneshot_cnt;
    reg        event_active;
    reg        next_event;
    reg        next_pulse;

    // Event source selection
    always @*
    begin
        next_event = 1'b0;
        next_pulse = 1'b0;
        if (enabled)
        begin
            case (mode)
                `ODA_MODE_BLOCKED:    next_event = 1'b0;
                `ODA_MODE_DIRECT:
                begin
                    if (cfg[`ODA_CFG_EDGE])
                        next_event = req_rise || (oneshot_cnt != 5'h00);
                    else
                        next_event = request;
                end
                `ODA_MODE_PULSER_PIN: next_pulse = req_rise;
                default:              next_pulse = burst_written;
            endcase
        end
    end

    // One-shot timer and outputs
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            oneshot_cnt        <= 5'h00;
            event_active       <= 1'b0;
            divider_reset      <= 7'h00;
            frame_ref_reset    <= 1'b0;
            pulser_trigger     <= 1'b0;
            frame_ref_enable   <= 1'b0;
            clear_setup_active <= 1'b0;
        end
        else
        begin
            if (enabled && mode == `ODA_MODE_DIRECT && cfg[`ODA_CFG_EDGE] && req_rise)
                oneshot_cnt <= ONESHOT_LOAD[4:0];
            else if (oneshot_cnt != 5'h00)
                oneshot_cnt <= oneshot_cnt - 5'h01;
            event_active       <= next_event;
            divider_reset      <= next_event ? ~exclude[6:0] : 7'h00;
            frame_ref_reset    <= next_event && !exclude[7];
            pulser_trigger     <= next_pulse;
            frame_ref_enable   <= !power[`ODA_POWER_FRAME_PD];
            clear_setup_active <= cfg[`ODA_CFG_CLEAR_SETUP];
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    wire [11:0] ridx = reg_index(s_axi_araddr);

    // Read data selection and handshake
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
            if (ridx == `ODA_IDX_CONFIG)
                s_axi_rdata <= {24'h000000, cfg};
            else if (ridx == `ODA_IDX_EXCLUDE)
                s_axi_rdata <= {24'h000000, exclude};
            else if (ridx == `ODA_IDX_POWER)
                s_axi_rdata <= {24'h000000, power};
            else if (ridx == `ODA_IDX_BURST)
                s_axi_rdata <= {24'h000000, burst};
            else if (ridx == `ODA_IDX_STATUS)
                s_axi_rdata <= {28'h0000000, l2_sync[1], l1_sync[1], pin_level,
                                event_active};
            else
                s_axi_rdata <= 32'h0000_0000;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // oda_align_ctrl

// ==== test/oda_checker.sv ====
// Port-level checks for the alignment control block.
// Bound to every oda_align_ctrl; one clock, sync active-low reset.
module oda_checker
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [6:0]  divider_reset,
    input wire logic        frame_ref_reset,
    input wire logic        pulser_trigger,
    input wire logic        frame_ref_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // Bus and event sequences
    // ----------------------------------------
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_pd_long;
        !frame_ref_enable [*8];
    endsequence
    chk_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write not answered two cycles after acceptance");
    chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_wr_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_rd_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    chk_b_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_pulse_single: assert property (pulser_trigger |=> !pulser_trigger)
        else $error("pulser trigger longer than one cycle");
    chk_pd_quiet: assert property (s_pd_long |-> divider_reset == 7'h00 && !frame_ref_reset)
        else $error("event while frame reference powered down");
    chk_group_move: assert property ($changed(divider_reset)
        |-> divider_reset == 7'h00 || $past(divider_reset) == 7'h00)
        else $error("dividers not reset together");
endmodule // oda_checker

bind oda_align_ctrl oda_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .divider_reset, .frame_ref_reset,
    .pulser_trigger, .frame_ref_enable);

// ==== test/oda_host_model.sv ====
// Host-side model driving the request pin and both lock flags.
// Changes its outputs just after a rising edge of aclk.
module oda_host_model
(
    input  wire logic aclk,
    output logic      align_request_pin,
    output logic      loop1_lock,
    output logic      loop2_lock
);
    timeunit 1ns;
    timeprecision 1ns;
    // Locked and idle at start, so no hold is pending
    initial {align_request_pin, loop1_lock, loop2_lock} = 3'b011;
    // New pin and lock levels after the next edge
    task automatic drive(input logic p, input logic a, input logic b);
        @(posedge aclk);
        align_request_pin <= p;
        loop1_lock        <= a;
        loop2_lock        <= b;
    endtask
endmodule // oda_host_model

// ==== test/testbench.sv ====
// Self-checking bench for oda_align_ctrl against a register and event model.
// Assumes the host model and the bound checker; index times four is the address.
`include "oda_regs.vh"
`define CHK(n, e, a) begin num_checks++; if ((e) !== (a)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, align_request_pin, loop1_lock, loop2_lock, frame_ref_reset;
    logic        pulser_trigger, frame_ref_enable, clear_setup_active;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [6:0]  divider_reset;
    logic [7:0]  mdl [int];
    logic [7:0]  cfgs [5] = '{8'h11, 8'h31, 8'h01, 8'h10, 8'h12};
    int          error_cnt, num_checks, cyc, pcnt;
    localparam int CFG = `ODA_IDX_CONFIG;
    oda_align_ctrl u_oda_align_ctrl (.*);
    oda_host_model host (.*);
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Pulse counter and run limit
    always @(posedge aclk)
    begin
        cyc++;
        if (pulser_trigger === 1'b1) pcnt++;
        if (cyc == 8000)
        begin
            error_cnt++;
            results();
        end
    end
    task automatic wr(input int i, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= 12'(i * 4);
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", mdl.exists(i) ? 2'h0 : 2'h2, s_axi_bresp)
        if (mdl.exists(i)) mdl[i] = d;
    endtask
    task automatic rd(input int i);
        @(posedge aclk);
        s_axi_araddr  <= 12'(i * 4);
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK("rdata", mdl.exists(i) ? {24'h0, mdl[i]} : 32'h0, s_axi_rdata)
        `CHK("rresp", mdl.exists(i) ? 2'h0 : 2'h2, s_axi_rresp)
    endtask
    // Expected {frame reset, divider resets} for a request level
    function automatic logic [7:0] exp_ev(input logic act);
        logic [7:0] c;
        c = mdl[CFG];
        act = act | (c[3] & ~loop2_lock) | (c[2] & ~loop1_lock);
        if (act && c[4] && c[1:0] == 2'h1 && !mdl[`ODA_IDX_POWER][2]) return ~mdl[CFG + 1];
        return 8'h00;
    endfunction
    task automatic ev_chk(input int w, input logic act);
        repeat (w) @(posedge aclk);
        `CHK("event", exp_ev(act), {frame_ref_reset, divider_reset})
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hf;
        void'($urandom(32'h62315d82));
        mdl[`ODA_IDX_BURST] = 8'h00;
        mdl[`ODA_IDX_POWER] = 8'h00;
        mdl[CFG] = 8'h01;
        mdl[CFG + 1] = 8'h00;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, unmapped index both ways
        rd(`ODA_IDX_POWER);
        rd(CFG);
        rd(CFG + 1);
        rd('h145);
        wr('h145, 8'h5a);
        $display("reset test done");
        // Source settings 0 to 2, normal and inverted pin, random exclusions
        foreach (cfgs[k])
        begin
            wr(CFG + 1, 8'($urandom));
            wr(CFG, cfgs[k]);
            rd(CFG);
            pcnt = 0;
            host.drive(~cfgs[k][5], 1'b1, 1'b1);
            ev_chk(6, 1'b1);
            ev_chk(14, 1'b1);
            `CHK("pulses", cfgs[k][1:0] == 2'h2 && cfgs[k][4], pcnt != 0)
            host.drive(cfgs[k][5], 1'b1, 1'b1);
            ev_chk(6, 1'b0);
        end
        $display("source test done");
        // Edge mode ends before the request does
        wr(CFG, 8'h51);
        host.drive(1'b1, 1'b1, 1'b1);
        ev_chk(6, 1'b1);
        ev_chk(20, 1'b0);
        host.drive(1'b0, 1'b1, 1'b1);
        // Hold until each loop reports lock
        for (int k = 0; k < 2; k++)
        begin
            wr(CFG, 8'h11 | (8'h04 << k));
            host.drive(1'b0, k[0], ~k[0]);
            ev_chk(6, 1'b0);
            host.drive(1'b0, 1'b1, 1'b1);
            ev_chk(6, 1'b0);
        end
        $display("edge and lock hold test done");
        // Frame reference powered down blocks events
        wr(`ODA_IDX_POWER, 8'h04);
        wr(CFG, 8'h11);
        host.drive(1'b1, 1'b1, 1'b1);
        ev_chk(10, 1'b1);
        `CHK("fre", 1'b0, frame_ref_enable)
        host.drive(1'b0, 1'b1, 1'b1);
        wr(`ODA_IDX_POWER, 8'h00);
        ev_chk(4, 1'b0);
        `CHK("fre", 1'b1, frame_ref_enable)
        // Burst writes trigger the pulser, then clear-setup copy
        wr(CFG, 8'h13);
        pcnt = 0;
        wr(`ODA_IDX_BURST, 8'h03);
        repeat (4) @(posedge aclk);
        `CHK("burst", 1, pcnt)
        wr(CFG, 8'h80);
        repeat (3) @(posedge aclk);
        `CHK("clr", 1'b1, clear_setup_active)
        wr(CFG, 8'h01);
        repeat (3) @(posedge aclk);
        `CHK("clr", 1'b0, clear_setup_active)
        $display("pulser test done");
        results();
    end
endmodule // testbench
